// ---- usb_ep0_pkg.sv ----
// Package for the endpoint 0 OUT transfer-size block.
// Assumes a single 20 MHz clock and a simple strobe register port.
package usb_ep0_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_XFER_SIZE = 8'h00;
  localparam logic [7:0] OFS_CTRL      = 8'h04;
  localparam logic [7:0] OFS_INT_STAT  = 8'h08;
  localparam logic [7:0] OFS_INT_MASK  = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and widths of the transfer-size register
  // ----------------------------------------------------------------
  localparam int SETUP_LSB = 29;
  localparam int SETUP_W   = 2;
  localparam int TALLY_LSB = 19;
  localparam int TALLY_W   = 1;
  localparam int LEN_LSB   = 0;
  localparam int LEN_W     = 7;

  // Reset values of the fields.
  localparam logic [SETUP_W-1:0] SETUP_RST = 2'h0;
  localparam logic [TALLY_W-1:0] TALLY_RST = 1'h0;
  localparam logic [LEN_W-1:0]   LEN_RST   = 7'h00;

  // Control register: bit of the endpoint enable.
  localparam int CTRL_EN_BIT = 0;

  // Interrupt status and mask bit positions.
  localparam int IRQ_W        = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_B2B_BIT  = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Greatest run of back-to-back SETUP packets that is not an excess.
  localparam logic [2:0] SETUP_RUN_MAX = 3'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One receive event from the packet engine.
  typedef struct packed {
    logic             pkt_written;
    logic             setup_pkt;
    logic [LEN_W-1:0] bytes;
  } rx_event_t;

  // Register port request from software.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Endpoint ownership state.
  typedef enum logic [1:0] {
    ST_SW  = 2'b01,
    ST_HW  = 2'b10
  } own_state_t;

endpackage : usb_ep0_pkg

// ---- usb_ep0_irq.sv ----
// Sticky interrupt status with mask and one level output.
// Assumes events are one-cycle pulses on the same clock as software.
`timescale 1ns/100ps
module usb_ep0_irq #(
  parameter int W = 2
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_event,
  input  wire logic         i_clr_wr,
  input  wire logic         i_mask_wr,
  input  wire logic [W-1:0] i_wdata,
  output logic      [W-1:0] o_status,
  output logic      [W-1:0] o_mask,
  output logic              o_irq
);
  import usb_ep0_pkg::*;

  logic [W-1:0] stat_reg;
  logic [W-1:0] stat_next;
  logic [W-1:0] mask_reg;
  logic [W-1:0] mask_next;

  // Write one clears a status bit; a new event in the same cycle wins.
  always_comb begin
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (i_clr_wr) begin
      stat_next = stat_next & ~i_wdata;
    end
    stat_next = stat_next | i_event;
    if (i_mask_wr) begin
      mask_next = i_wdata;
    end
  end

  // Registers only.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stat_reg <= IRQ_RST;
      mask_reg <= IRQ_RST;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  assign o_status = stat_reg;
  assign o_mask   = mask_reg;
  assign o_irq    = |(stat_reg & mask_reg);

endmodule : usb_ep0_irq

// ---- usb_ep0_out_transfer_size.sv ----
// Endpoint 0 OUT transfer-size bookkeeping with its register port.
// Assumes receive events come from logic on i_mclk and software uses a
// one-cycle strobe port with read data in the following cycle.
`timescale 1ns/100ps

// Summary of operation
// - Enabled endpoint: controller owns and updates register.
// - SETUP allowance two bits, resets zero.
// - Packet tally resets zero, clears to zero per written packet.
// - Byte length counts bytes, resets zero.
// - Byte length reaching zero raises interrupt.
// - Byte length decreases per written packet.
// - More than three SETUPs flags excess.
module usb_ep0_out_transfer_size (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire usb_ep0_pkg::reg_req_t  i_req,
  input  wire usb_ep0_pkg::rx_event_t i_rx,
  output logic [31:0]                 o_rdata,
  output logic                        o_ep_enabled,
  output logic                        o_irq
);
  import usb_ep0_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  own_state_t         own_reg;
  own_state_t         own_next;
  logic [SETUP_W-1:0] setup_reg;
  logic [SETUP_W-1:0] setup_next;
  logic [TALLY_W-1:0] tally_reg;
  logic [TALLY_W-1:0] tally_next;
  logic [LEN_W-1:0]   len_reg;
  logic [LEN_W-1:0]   len_next;
  logic [2:0]         run_reg;
  logic [2:0]         run_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  logic [IRQ_W-1:0]   irq_event;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_mask;
  logic               wr_size;
  logic               wr_ctrl;
  logic               enabled;
  logic               done_evt;
  logic               excess_setup_flag;
  logic [31:0]        size_word;

  // Address decode of the write strobe.
  assign wr_size = i_req.wr && (i_req.addr == OFS_XFER_SIZE);
  assign wr_ctrl = i_req.wr && (i_req.addr == OFS_CTRL);
  assign enabled = (own_reg == ST_HW);

  // Live register image; reserved bits read as zero.
  always_comb begin
    size_word = 32'h0000_0000;
    size_word[SETUP_LSB +: SETUP_W] = setup_reg;
    size_word[TALLY_LSB +: TALLY_W] = tally_reg;
    size_word[LEN_LSB +: LEN_W]     = len_reg;
  end

  // ----------------------------------------------------------------
  // Ownership and field update
  // ----------------------------------------------------------------
  // Software may load the fields only while it owns the register, so a
  // late write cannot corrupt counters the controller is working on.
  always_comb begin
    own_next   = own_reg;
    setup_next = setup_reg;
    tally_next = tally_reg;
    len_next   = len_reg;
    done_evt   = 1'b0;
    case (own_reg)
      ST_SW: begin
        if (wr_size) begin
          setup_next = i_req.wdata[SETUP_LSB +: SETUP_W];
          tally_next = i_req.wdata[TALLY_LSB +: TALLY_W];
          len_next   = i_req.wdata[LEN_LSB +: LEN_W];
        end
        if (wr_ctrl && i_req.wdata[CTRL_EN_BIT]) begin
          own_next = ST_HW;
        end
      end
      ST_HW: begin
        if (i_rx.setup_pkt && (setup_reg != 2'h0)) begin
          setup_next = setup_reg - 2'h1;
        end
        if (i_rx.pkt_written) begin
          tally_next = TALLY_RST;
          if (i_rx.bytes >= len_reg) begin
            len_next = LEN_RST;
          end else begin
            len_next = len_reg - i_rx.bytes;
          end
          if (len_next == LEN_RST) begin
            done_evt = 1'b1;
            own_next = ST_SW;
          end
        end
        // Software may abort by writing the enable bit low.
        if (wr_ctrl && !i_req.wdata[CTRL_EN_BIT]) begin
          own_next = ST_SW;
        end
      end
      default: begin
        own_next = ST_SW;
      end
    endcase
  end

  // Registers of ownership and fields.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      own_reg   <= ST_SW;
      setup_reg <= SETUP_RST;
      tally_reg <= TALLY_RST;
      len_reg   <= LEN_RST;
    end else begin
      own_reg   <= own_next;
      setup_reg <= setup_next;
      tally_reg <= tally_next;
      len_reg   <= len_next;
    end
  end

  // ----------------------------------------------------------------
  // Back-to-back SETUP run counter
  // ----------------------------------------------------------------
  // A data packet breaks the run; the counter saturates above three.
  always_comb begin
    run_next          = run_reg;
    excess_setup_flag = 1'b0;
    if (i_rx.pkt_written && !i_rx.setup_pkt) begin
      run_next = 3'h0;
    end else if (i_rx.setup_pkt) begin
      if (run_reg >= SETUP_RUN_MAX) begin
        excess_setup_flag = 1'b1;
        run_next          = SETUP_RUN_MAX + 3'h1;
      end else begin
        run_next = run_reg + 3'h1;
      end
    end
  end

  // Register of the run counter.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      run_reg <= 3'h0;
    end else begin
      run_reg <= run_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_event               = IRQ_RST;
    irq_event[IRQ_DONE_BIT] = done_evt;
    irq_event[IRQ_B2B_BIT]  = excess_setup_flag;
  end

  usb_ep0_irq #(
    .W (IRQ_W)
  ) u_irq (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_event   (irq_event),
    .i_clr_wr  (i_req.wr && (i_req.addr == OFS_INT_STAT)),
    .i_mask_wr (i_req.wr && (i_req.addr == OFS_INT_MASK)),
    .i_wdata   (i_req.wdata[IRQ_W-1:0]),
    .o_status  (irq_status),
    .o_mask    (irq_mask),
    .o_irq     (o_irq)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data stand one cycle after the strobe and are zero otherwise.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_req.rd) begin
      case (i_req.addr)
        OFS_XFER_SIZE: rdata_next = size_word;
        OFS_CTRL:      rdata_next = {31'h0000_0000, enabled};
        OFS_INT_STAT:  rdata_next = {30'h0000_0000, irq_status};
        OFS_INT_MASK:  rdata_next = {30'h0000_0000, irq_mask};
        default:       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register of the read data.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata      = rdata_reg;
  assign o_ep_enabled = enabled;

endmodule : usb_ep0_out_transfer_size

// ---- usb_ep0_checker.sv ----
// Port checker for the endpoint 0 OUT transfer-size block.
// Assumes one clock and the synchronous active-high reset of the block.
`timescale 1ns/100ps
module usb_ep0_checker
  import usb_ep0_pkg::*;
(
  input wire logic      i_mclk,
  input wire logic      i_rst,
  input wire reg_req_t  i_req,
  input wire rx_event_t i_rx,
  input wire logic [31:0] o_rdata,
  input wire logic      o_ep_enabled,
  input wire logic      o_irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  reset_quiet_a: assert property ($past(i_rst) |-> !o_ep_enabled && !o_irq && o_rdata == 32'h0)
    else $error("outputs not cleared by reset");
  rdata_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == 32'h0)
    else $error("read data outside read answer");
  enable_set_a: assert property (i_req.wr && i_req.addr == OFS_CTRL && i_req.wdata[0] |=> o_ep_enabled)
    else $error("enable write not taken");
  enable_fall_a: assert property (!$past(i_rst) && $fell(o_ep_enabled) |-> $past(i_rx.pkt_written || i_req.wr))
    else $error("enable dropped without cause");
  irq_rise_a: assert property ($rose(o_irq) |-> $past(i_rx.pkt_written || i_rx.setup_pkt || i_req.wr))
    else $error("interrupt without event");
  irq_fall_a: assert property (!$past(i_rst) && $fell(o_irq) |-> $past(i_req.wr))
    else $error("interrupt dropped without write");
  size_reserved_a: assert property (i_req.rd && i_req.addr == OFS_XFER_SIZE |=> (o_rdata & 32'h9FF7FF80) == 32'h0)
    else $error("reserved size bits set");
  unmapped_read_a: assert property (i_req.rd && i_req.addr > OFS_INT_MASK |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  enable_c: cover property ($rose(o_ep_enabled));
  irq_c: cover property ($rose(o_irq));
  done_c: cover property ($fell(o_ep_enabled));
endmodule : usb_ep0_checker
bind usb_ep0_out_transfer_size usb_ep0_checker u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_req(i_req), .i_rx(i_rx), .o_rdata(o_rdata), .o_ep_enabled(o_ep_enabled), .o_irq(o_irq));

// ---- usb_host_model.sv ----
// Host-side model that delivers receive events as one-cycle pulses.
// Assumes the block samples events on the rising clock edge.
`timescale 1ns/100ps
module usb_host_model (
  input  wire logic               i_mclk,
  output usb_ep0_pkg::rx_event_t  o_rx
);
  import usb_ep0_pkg::*;
  initial o_rx = '0;
  // Sends one SETUP or one OUT data packet of n bytes.
  task automatic send(input logic setup, input logic [6:0] n);
    @(posedge i_mclk);
    o_rx <= '{~setup, setup, n};
    @(posedge i_mclk);
    o_rx <= '0;
    #1;
  endtask : send
endmodule : usb_host_model

// ---- usb_ep0_out_transfer_size_test.sv ----
// Testbench for the endpoint 0 OUT transfer-size block.
// Assumes the package, the design, the host model and the checker.
`timescale 1ns/100ps
module usb_ep0_out_transfer_size_test;
  import usb_ep0_pkg::*;
  logic      i_mclk = 1'b0;
  logic      i_rst  = 1'b1;
  reg_req_t  req    = '0;
  rx_event_t rx;
  logic [31:0] rdata;
  logic      en;
  logic      irq;
  int        miscompares = 0;
  int        cmp_count = 0;
  int        cycles = 0;
  // Packet limit of the endpoint in this test; the value is a plain choice.
  localparam logic [6:0] MAX_PKT = 7'h08;
  always #25 i_mclk = ~i_mclk;
  usb_host_model host (.i_mclk(i_mclk), .o_rx(rx));
  usb_ep0_out_transfer_size uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .i_rx(rx),
    .o_rdata(rdata), .o_ep_enabled(en), .o_irq(irq));
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_mclk);
    req <= '0;
    #1;
    chk("rdata", e, rdata);
  endtask : rd
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // Cuts a hang short.
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(OFS_XFER_SIZE, 32'h0);
    rd(OFS_INT_STAT, 32'h0);
    wr(OFS_XFER_SIZE, 32'h60080005);
    rd(OFS_XFER_SIZE, 32'h60080005);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1);
    wr(OFS_XFER_SIZE, 32'h0);
    host.send(1'b1, 7'h00);
    rd(OFS_XFER_SIZE, 32'h40080005);
    wr(OFS_INT_MASK, 32'h1);
    host.send(1'b0, 7'h03);
    rd(OFS_XFER_SIZE, 32'h40000002);
    chk("irq", 32'h0, {31'h0, irq});
    host.send(1'b0, 7'h02);
    chk("irq", 32'h1, {31'h0, irq});
    rd(OFS_CTRL, 32'h0);
    rd(OFS_XFER_SIZE, 32'h40000000);
    rd(OFS_INT_STAT, 32'h1);
    wr(OFS_INT_STAT, 32'h1);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_INT_MASK, 32'h3);
    repeat (3) host.send(1'b1, 7'h00);
    rd(OFS_INT_STAT, 32'h0);
    host.send(1'b1, 7'h00);
    rd(OFS_INT_STAT, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    rd(8'h10, 32'h0);
    // A data packet while disabled breaks the SETUP run and leaves the fields alone.
    wr(OFS_INT_STAT, 32'h3);
    host.send(1'b0, 7'h01);
    rd(OFS_XFER_SIZE, 32'h40000000);
    chk("irq", 32'h0, {31'h0, irq});
    // Length set to one packet, so one full packet of MAX_PKT bytes ends the transfer.
    wr(OFS_XFER_SIZE, 32'h2008_0000 | {25'h0, MAX_PKT});
    wr(OFS_CTRL, 32'h1);
    #1;
    chk("en", 32'h1, {31'h0, en});
    // Allowance of one stays at zero after a second SETUP.
    repeat (2) host.send(1'b1, 7'h00);
    rd(OFS_XFER_SIZE, 32'h0008_0000 | {25'h0, MAX_PKT});
    host.send(1'b0, MAX_PKT);
    chk("irq", 32'h1, {31'h0, irq});
    chk("en", 32'h0, {31'h0, en});
    rd(OFS_XFER_SIZE, 32'h0);
    // Abort by writing the enable low; later packets change nothing.
    wr(OFS_XFER_SIZE, 32'h0008_0010);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h0);
    #1;
    chk("en", 32'h0, {31'h0, en});
    host.send(1'b0, 7'h03);
    rd(OFS_XFER_SIZE, 32'h0008_0010);
    // Reset in mid-run while enabled and with an interrupt pending.
    wr(OFS_CTRL, 32'h1);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk("en", 32'h0, {31'h0, en});
    chk("irq", 32'h0, {31'h0, irq});
    rd(OFS_XFER_SIZE, 32'h0);
    rd(OFS_INT_STAT, 32'h0);
    rd(OFS_INT_MASK, 32'h0);
    complete_run();
  end
endmodule : usb_ep0_out_transfer_size_test
